// [pdbw_walker.sv]
// What this block does
// - next header from next/match/mismatch/expiry pointer
// - data block read right after header
// - messages use the ordinary mailbox transfer
// - kind 1 jumps to its next pointer
// - only low byte of each word sent
// - write block field layout, length gives bytes
// - sent goes next, stuck mailbox goes expiry
// - kind 3: next message match/mismatch/timeout
// - kind 4: discard others until match/timeout
// - always keep the latest received message
// - kind 5 compares stored message, no wait
// - compare low bytes, count from length field
// - store up to 256 payload bytes
// - kind 6 loads the four globals
// - globals start 0400 hex and zero
// - globals stand in for missing local fields
// - status starts FFF hex, kind 7 sets
// - status judged at image end, zero good
// - unknown kind follows the skip pointer
// - pointers are byte offsets into image
`timescale 1ns/100ps
module pdbw_walker import pdbw_pkg::*; #(
  parameter int MS_CYCLES = PDBW_MS_CYCLES
) (
  input wire logic ref_clk_in, // 40 MHz clock
  input wire logic rst_in, // async reset, high
  input wire logic start_in, // begin download
  input wire logic [31:0] first_ptr_in, // first block header
  input wire logic [31:0] img_len_in, // image size in bytes
  output logic img_rd_out, // image byte read strobe
  output logic [31:0] img_addr_out, // image byte offset
  input wire logic img_valid_in, // read data valid
  input wire logic [7:0] img_data_in, // read data byte
  output logic tx_valid_out, // message byte valid
  output logic [7:0] tx_data_out, // message byte
  output logic tx_last_out, // last message byte
  input wire logic tx_ready_in, // mailbox takes byte
  input wire logic rx_valid_in, // device message byte
  input wire logic [7:0] rx_data_in, // device message data
  input wire logic rx_last_in, // last byte of message
  output logic rx_ready_out, // always accepting
  output logic busy_out, // walking the image
  output logic done_out, // image end reached
  output logic ok_out, // download succeeded
  output logic [15:0] status_out, // download status
  output logic [7:0] glob_sel_out, // global selector
  output logic [7:0] glob_ctl_out // global control-high
);
  pdbw_state_t st_reg, ret_reg;
  logic [31:0] ptr_reg, base_reg, kind_reg, skip_reg, nxt_reg;
  logic [31:0] tptr_reg, fptr_reg, gexp_reg, gtmo_reg, fbase_reg;
  logic [31:0] fa_reg, acc_reg;
  logic [1:0] fi_reg, fn_reg;
  logic [2:0] fld_reg;
  logic [8:0] k_reg;
  logic [7:0] len_reg, pb_reg;
  logic pl_reg, mism_reg;
  logic [7:0] rx_hdr [PDBW_RX_HDR_BYTES];
  logic [7:0] rx_mem [PDBW_MAILBOX_PAYLOAD_BYTES];
  logic [8:0] rx_idx_reg;
  logic rx_new_reg, rx_take;
  logic [31:0] msdiv_reg, ms_reg;
  logic tmr_clr, expired;
  logic ob_v_reg, sk_v_reg, sk_l_reg, push, in_rdy, buf_empty;
  logic [7:0] sk_d_reg;
  wire [7:0] byte_w = acc_reg[7:0];
  wire [8:0] last_k = 9'(byte_w) + 9'h002;
  wire [8:0] elast_k = 9'(len_reg) + 9'h002;
  wire [8:0] pay_k = k_reg - 9'h003;
  wire [7:0] stored = (k_reg < 9'h003) ? rx_hdr[k_reg[1:0]]
                                        : rx_mem[pay_k[7:0]];
  wire cmp_bad = mism_reg || (byte_w != stored);
  wire cmp_end = (k_reg == ((k_reg == 9'h002) ? last_k : elast_k));
  wire [31:0] k_ofs = {22'h0, k_reg, 1'b0};
  wire [1:0] acc_sh = fi_reg;

  assign in_rdy = !sk_v_reg;
  assign buf_empty = !ob_v_reg && !sk_v_reg;
  assign push = (st_reg == PDBW_PUSH) && in_rdy && !expired;
  assign tmr_clr = (st_reg == PDBW_DISP);
  assign expired = (ms_reg >= gtmo_reg);
  assign rx_take = (st_reg == PDBW_RXW) && rx_new_reg;
  logic [7:0] sel_g, ctl_g;
  assign glob_sel_out = sel_g;
  assign glob_ctl_out = ctl_g;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      msdiv_reg <= 32'h0;
      ms_reg <= 32'h0;
    end else if (tmr_clr) begin
      msdiv_reg <= 32'h0;
      ms_reg <= 32'h0;
    end else if (msdiv_reg == 32'(MS_CYCLES - 1)) begin
      msdiv_reg <= 32'h0;
      ms_reg <= expired ? ms_reg : ms_reg + 32'h1;
    end else begin
      msdiv_reg <= msdiv_reg + 32'h1;
    end
  end

  // two-entry output buffer: output stage plus skid stage
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ob_v_reg <= 1'b0;
      tx_data_out <= 8'h0;
      tx_last_out <= 1'b0;
      sk_v_reg <= 1'b0;
      sk_d_reg <= 8'h0;
      sk_l_reg <= 1'b0;
    end else if (!ob_v_reg || tx_ready_in) begin
      if (sk_v_reg) begin
        ob_v_reg <= 1'b1;
        tx_data_out <= sk_d_reg;
        tx_last_out <= sk_l_reg;
        sk_v_reg <= 1'b0;
      end else begin
        ob_v_reg <= push;
        tx_data_out <= pb_reg;
        tx_last_out <= pl_reg;
      end
    end else if (push) begin
      sk_v_reg <= 1'b1;
      sk_d_reg <= pb_reg;
      sk_l_reg <= pl_reg;
    end
  end
  assign tx_valid_out = ob_v_reg;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_idx_reg <= 9'h0;
      rx_new_reg <= 1'b0;
      rx_ready_out <= 1'b0;
    end else begin
      rx_ready_out <= 1'b1;
      if (rx_valid_in) begin
        if (rx_idx_reg < 9'(PDBW_RX_HDR_BYTES)) begin
          rx_hdr[rx_idx_reg[1:0]] <= rx_data_in;
        end else if (rx_idx_reg < 9'(PDBW_MAILBOX_PAYLOAD_BYTES + 3)) begin
          rx_mem[8'(rx_idx_reg - 9'h003)] <= rx_data_in;
        end
        rx_idx_reg <= rx_last_in ? 9'h0 : rx_idx_reg + 9'h1;
      end
      // a message older than the block is not the next one
      if (rx_valid_in && rx_last_in) begin
        rx_new_reg <= 1'b1;
      end else if (rx_take || tmr_clr) begin
        rx_new_reg <= 1'b0;
      end
    end
  end

  // main walker
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg <= PDBW_IDLE;
      ret_reg <= PDBW_IDLE;
      {ptr_reg, base_reg, kind_reg, skip_reg, nxt_reg} <= '0;
      {tptr_reg, fptr_reg, gexp_reg, fbase_reg, fa_reg} <= '0;
      acc_reg <= 32'h0;
      gtmo_reg <= PDBW_TMO_INIT;
      {fi_reg, fn_reg, fld_reg, k_reg, len_reg, pb_reg} <= '0;
      {pl_reg, mism_reg, sel_g, ctl_g} <= '0;
      img_rd_out <= 1'b0;
      img_addr_out <= 32'h0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      ok_out <= 1'b0;
      status_out <= PDBW_STATUS_INIT;
    end else begin
      img_rd_out <= 1'b0;
      case (st_reg)
        PDBW_IDLE: if (start_in) begin
          ptr_reg <= first_ptr_in;
          gexp_reg <= 32'h0;
          gtmo_reg <= PDBW_TMO_INIT;
          sel_g <= 8'h0;
          ctl_g <= 8'h0;
          status_out <= PDBW_STATUS_INIT;
          done_out <= 1'b0;
          busy_out <= 1'b1;
          st_reg <= PDBW_CHK;
        end
        PDBW_CHK: if (ptr_reg >= img_len_in) begin
          done_out <= 1'b1;
          ok_out <= (status_out == 16'h0);
          busy_out <= 1'b0;
          st_reg <= PDBW_IDLE;
        end else begin
          fa_reg <= ptr_reg;
          fn_reg <= PDBW_DWORD_LAST;
          ret_reg <= PDBW_HDR;
          fld_reg <= 3'h0;
          st_reg <= PDBW_REQ;
        end
        PDBW_REQ: begin
          img_rd_out <= 1'b1;
          img_addr_out <= fa_reg + 32'(fi_reg);
          st_reg <= PDBW_WAIT;
        end
        PDBW_WAIT: if (img_valid_in) begin
          if (fi_reg == 2'h0) begin
            acc_reg <= {24'h0, img_data_in};
          end else begin
            acc_reg[8*acc_sh +: 8] <= img_data_in;
          end
          fi_reg <= (fi_reg == fn_reg) ? 2'h0 : fi_reg + 2'h1;
          st_reg <= (fi_reg == fn_reg) ? ret_reg : PDBW_REQ;
        end
        PDBW_HDR: if (fld_reg == 3'h0) begin
          kind_reg <= acc_reg;
          fa_reg <= ptr_reg + PDBW_HDR_SKIP_OFS;
          fld_reg <= 3'h1;
          st_reg <= PDBW_REQ;
        end else begin
          skip_reg <= acc_reg;
          base_reg <= ptr_reg + PDBW_HDR_LEN;
          st_reg <= PDBW_DISP;
        end
        PDBW_DISP: begin
          fa_reg <= base_reg;
          fn_reg <= PDBW_DWORD_LAST;
          fld_reg <= 3'h0;
          k_reg <= 9'h0;
          mism_reg <= 1'b0;
          st_reg <= PDBW_REQ;
          // pick handler state by block kind
          case (kind_reg)
            PDBW_KIND_JUMP: ret_reg <= PDBW_JMP;
            PDBW_KIND_WRMSG: ret_reg <= PDBW_WR;
            PDBW_KIND_NEXTMSG, PDBW_KIND_SPECMSG,
            PDBW_KIND_LASTMSG: ret_reg <= PDBW_CMPP;
            PDBW_KIND_SETGLOB: ret_reg <= PDBW_SETG;
            PDBW_KIND_SETSTAT: ret_reg <= PDBW_SETS;
            default: begin
              ptr_reg <= skip_reg;
              st_reg <= PDBW_CHK;
            end
          endcase
        end
        PDBW_JMP: begin
          ptr_reg <= acc_reg;
          st_reg <= PDBW_CHK;
        end
        PDBW_WR: begin
          if (fld_reg == 3'h0) begin
            nxt_reg <= acc_reg;
            fld_reg <= 3'h1;
          end else begin
            pb_reg <= byte_w;
            if (k_reg == 9'h002) len_reg <= byte_w;
            pl_reg <= cmp_end;
            st_reg <= PDBW_PUSH;
          end
          if (fld_reg == 3'h0) begin
            fa_reg <= base_reg + PDBW_WR_SEL_OFS;
            fn_reg <= PDBW_WORD_LAST;
            st_reg <= PDBW_REQ;
          end
        end
        PDBW_PUSH: if (expired) begin
          ptr_reg <= gexp_reg;
          st_reg <= PDBW_CHK;
        end else if (in_rdy) begin
          k_reg <= k_reg + 9'h1;
          fa_reg <= base_reg + PDBW_WR_SEL_OFS + k_ofs + 32'h2;
          st_reg <= pl_reg ? PDBW_DRAIN : PDBW_REQ;
        end
        PDBW_DRAIN: if (buf_empty) begin
          ptr_reg <= nxt_reg;
          st_reg <= PDBW_CHK;
        end else if (expired) begin
          ptr_reg <= gexp_reg;
          st_reg <= PDBW_CHK;
        end
        PDBW_CMPP: begin
          fn_reg <= PDBW_WORD_LAST;
          if (fld_reg == 3'h0) begin
            tptr_reg <= acc_reg;
            fld_reg <= 3'h1;
            if (kind_reg == PDBW_KIND_SPECMSG) begin
              fbase_reg <= base_reg + PDBW_CMP1_SEL_OFS;
              st_reg <= PDBW_RXW;
            end else begin
              fa_reg <= base_reg + PDBW_CMP_FALSE_OFS;
              fn_reg <= PDBW_DWORD_LAST;
              st_reg <= PDBW_REQ;
            end
          end else begin
            fptr_reg <= acc_reg;
            fbase_reg <= base_reg + PDBW_CMP2_SEL_OFS;
            fa_reg <= base_reg + PDBW_CMP2_SEL_OFS;
            ret_reg <= PDBW_CMPB;
            st_reg <= (kind_reg == PDBW_KIND_LASTMSG) ? PDBW_REQ
                                                      : PDBW_RXW;
          end
        end
        PDBW_RXW: if (rx_new_reg) begin
          k_reg <= 9'h0;
          mism_reg <= 1'b0;
          fa_reg <= fbase_reg;
          ret_reg <= PDBW_CMPB;
          st_reg <= PDBW_REQ;
        end else if (expired) begin
          ptr_reg <= gexp_reg;
          st_reg <= PDBW_CHK;
        end
        PDBW_CMPB: begin
          mism_reg <= cmp_bad;
          if (k_reg == 9'h002) len_reg <= byte_w;
          k_reg <= k_reg + 9'h1;
          fa_reg <= fbase_reg + k_ofs + 32'h2;
          st_reg <= PDBW_REQ;
          if (cmp_end) begin
            if (!cmp_bad) begin
              ptr_reg <= tptr_reg;
              st_reg <= PDBW_CHK;
            end else if (kind_reg == PDBW_KIND_SPECMSG) begin
              st_reg <= PDBW_RXW;
            end else begin
              ptr_reg <= fptr_reg;
              st_reg <= PDBW_CHK;
            end
          end
        end
        PDBW_SETG: begin
          fld_reg <= fld_reg + 3'h1;
          fn_reg <= PDBW_DWORD_LAST;
          st_reg <= PDBW_REQ;
          case (fld_reg)
            3'h0: begin
              nxt_reg <= acc_reg;
              fa_reg <= base_reg + PDBW_G_EXP_OFS;
            end
            3'h1: begin
              gexp_reg <= acc_reg;
              fa_reg <= base_reg + PDBW_G_TMO_OFS;
            end
            3'h2: begin
              gtmo_reg <= acc_reg;
              fa_reg <= base_reg + PDBW_G_SEL_OFS;
              fn_reg <= PDBW_WORD_LAST;
            end
            3'h3: begin
              sel_g <= byte_w;
              fa_reg <= base_reg + PDBW_G_CTL_OFS;
              fn_reg <= PDBW_WORD_LAST;
            end
            default: begin
              ctl_g <= byte_w;
              ptr_reg <= nxt_reg;
              st_reg <= PDBW_CHK;
            end
          endcase
        end
        PDBW_SETS: if (fld_reg == 3'h0) begin
          nxt_reg <= acc_reg;
          fld_reg <= 3'h1;
          fa_reg <= base_reg + PDBW_ST_VAL_OFS;
          fn_reg <= PDBW_WORD_LAST;
          st_reg <= PDBW_REQ;
        end else begin
          status_out <= acc_reg[15:0];
          ptr_reg <= nxt_reg;
          st_reg <= PDBW_CHK;
        end
        default: st_reg <= PDBW_IDLE;
      endcase
    end
  end

  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  jump_target_a: assert property (
    st_reg == PDBW_JMP |=> ptr_reg == $past(acc_reg) ##1
    st_reg != PDBW_JMP) else $error("jump pointer not taken");
  skip_unknown_a: assert property (
    st_reg == PDBW_DISP && kind_reg > PDBW_KIND_SETSTAT
    |=> st_reg == PDBW_CHK && ptr_reg == $past(skip_reg))
    else $error("unknown block not skipped");
  start_globals_a: assert property (
    st_reg == PDBW_IDLE && start_in |=> gtmo_reg == PDBW_TMO_INIT
    && gexp_reg == 32'h0 && sel_g == 8'h0 && ctl_g == 8'h0)
    else $error("globals not initialised");
  status_init_a: assert property (
    st_reg == PDBW_IDLE && start_in |=> status_out == 16'h0fff)
    else $error("status not initialised");
  end_verdict_a: assert property (
    $rose(done_out) |-> ok_out == (status_out == 16'h0) && !busy_out)
    else $error("wrong download verdict");
  mailbox_payload_expiry_a: assert property (
    st_reg == PDBW_PUSH && expired |=> ptr_reg == $past(gexp_reg)
    && st_reg == PDBW_CHK) else $error("expiry pointer not taken");
  rx_latest_a: assert property (
    rx_valid_in && rx_last_in |=> rx_new_reg && rx_idx_reg == 9'h0)
    else $error("received message not kept");
  low_first_a: assert property (
    st_reg == PDBW_WAIT && img_valid_in && fi_reg == 2'h0
    |=> acc_reg[7:0] == $past(img_data_in))
    else $error("byte order wrong");
  last_match_a: assert property (
    st_reg == PDBW_CMPB && cmp_end && !cmp_bad
    |=> ptr_reg == $past(tptr_reg)) else $error("match pointer missed");
  byte_only_a: assert property (
    st_reg == PDBW_WR && fld_reg != 3'h0
    |=> st_reg == PDBW_PUSH && pb_reg == $past(acc_reg[7:0]))
    else $error("message byte wrong");
endmodule

// [pdbw_pkg.sv]
package pdbw_pkg;
  localparam logic [31:0] PDBW_KIND_JUMP = 32'h0000_0001;
  localparam logic [31:0] PDBW_KIND_WRMSG = 32'h0000_0002;
  localparam logic [31:0] PDBW_KIND_NEXTMSG = 32'h0000_0003;
  localparam logic [31:0] PDBW_KIND_SPECMSG = 32'h0000_0004;
  localparam logic [31:0] PDBW_KIND_LASTMSG = 32'h0000_0005;
  localparam logic [31:0] PDBW_KIND_SETGLOB = 32'h0000_0006;
  localparam logic [31:0] PDBW_KIND_SETSTAT = 32'h0000_0007;
  localparam logic [31:0] PDBW_HDR_SKIP_OFS = 32'h0000_0004;
  localparam logic [31:0] PDBW_HDR_LEN = 32'h0000_0008;
  localparam logic [31:0] PDBW_WR_SEL_OFS = 32'h0000_0004;
  localparam logic [31:0] PDBW_CMP_FALSE_OFS = 32'h0000_0004;
  localparam logic [31:0] PDBW_CMP2_SEL_OFS = 32'h0000_0008;
  localparam logic [31:0] PDBW_CMP1_SEL_OFS = 32'h0000_0004;
  localparam logic [31:0] PDBW_G_EXP_OFS = 32'h0000_0004;
  localparam logic [31:0] PDBW_G_TMO_OFS = 32'h0000_0008;
  localparam logic [31:0] PDBW_G_SEL_OFS = 32'h0000_000c;
  localparam logic [31:0] PDBW_G_CTL_OFS = 32'h0000_000e;
  localparam logic [31:0] PDBW_ST_VAL_OFS = 32'h0000_0004;
  localparam logic [31:0] PDBW_TMO_INIT = 32'h0000_0400;
  localparam logic [15:0] PDBW_STATUS_INIT = 16'h0fff;
  localparam logic [1:0] PDBW_DWORD_LAST = 2'h3;
  localparam logic [1:0] PDBW_WORD_LAST = 2'h1;
  localparam int PDBW_MS_NS = 1000000;
  localparam int PDBW_CLK_NS = 25;
  localparam int PDBW_MS_CYCLES = PDBW_MS_NS / PDBW_CLK_NS;
  localparam int PDBW_MAILBOX_PAYLOAD_BYTES = 256;
  localparam int PDBW_RX_HDR_BYTES = 3;
  typedef enum logic [4:0] {
    PDBW_IDLE, PDBW_CHK, PDBW_REQ, PDBW_WAIT, PDBW_HDR, PDBW_DISP,
    PDBW_JMP, PDBW_WR, PDBW_PUSH, PDBW_DRAIN, PDBW_CMPP, PDBW_RXW,
    PDBW_CMPB, PDBW_SETG, PDBW_SETS
  } pdbw_state_t;
endpackage

// [pdbw_dev_model.sv]
`timescale 1ns/100ps
// mailbox side of the device: takes host messages, sends its own
module pdbw_dev_model (
  input wire logic ref_clk_in, // clock
  input wire logic rst_in, // async reset, high
  input wire logic stall_in, // keep mailbox occupied
  input wire logic go_in, // send msg_in once
  input wire logic [31:0] msg_in, // sel, ctl, len, payload
  input wire logic tx_valid_in, // host byte valid
  input wire logic [7:0] tx_data_in, // host byte
  input wire logic tx_last_in, // host last byte
  output logic tx_ready_out, // mailbox free
  output logic rx_valid_out, // device byte valid
  output logic [7:0] rx_data_out, // device byte
  output logic rx_last_out, // device last byte
  output logic [31:0] cap_out, // last four bytes taken
  output logic [7:0] ncap_out // whole messages taken
);
  logic [31:0] sh_reg;
  logic [2:0] cnt_reg;
  assign tx_ready_out = ~stall_in;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cap_out <= 32'h0;
      ncap_out <= 8'h0;
    end else if (tx_valid_in && tx_ready_out) begin
      cap_out <= {cap_out[23:0], tx_data_in};
      if (tx_last_in) begin
        ncap_out <= ncap_out + 8'h1;
      end
    end
  end
  // device message, data toggles while idle
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sh_reg <= 32'h0;
      cnt_reg <= 3'h0;
      rx_valid_out <= 1'b0;
      rx_data_out <= 8'h0;
      rx_last_out <= 1'b0;
    end else if (go_in) begin
      sh_reg <= msg_in;
      cnt_reg <= 3'h4;
    end else if (cnt_reg != 3'h0) begin
      rx_valid_out <= 1'b1;
      rx_data_out <= sh_reg[31:24];
      rx_last_out <= (cnt_reg == 3'h1);
      sh_reg <= {sh_reg[23:0], 8'h0};
      cnt_reg <= cnt_reg - 3'h1;
    end else begin
      rx_valid_out <= 1'b0;
      rx_last_out <= 1'b0;
      rx_data_out <= ~rx_data_out;
    end
  end
endmodule

// [test_program_download_block_walker.sv]
`timescale 1ns/100ps
module test_program_download_block_walker;
  import pdbw_pkg::*;
  localparam logic [31:0] E = 32'h100;
  localparam logic [31:0] M = 32'h3f220133;
  logic ref_clk_in, rst_in, start_in, img_rd_out, img_valid_in;
  logic [31:0] first_ptr_in, img_len_in, img_addr_out, msg_in, cap;
  logic [7:0] img_data_in, tx_data_out, rx_data_in, ncap;
  logic [7:0] glob_sel_out, glob_ctl_out;
  logic tx_valid_out, tx_last_out, tx_ready_in, rx_valid_in, rx_last_in;
  logic rx_ready_out, busy_out, done_out, ok_out, stall, go;
  logic [15:0] status_out;
  logic [7:0] img [0:255];
  int err_count, n_checks;

  pdbw_walker #(.MS_CYCLES(20)) u_pdbw_walker (.ref_clk_in(ref_clk_in),
    .rst_in(rst_in), .start_in(start_in), .first_ptr_in(first_ptr_in),
    .img_len_in(img_len_in), .img_rd_out(img_rd_out),
    .img_addr_out(img_addr_out), .img_valid_in(img_valid_in),
    .img_data_in(img_data_in), .tx_valid_out(tx_valid_out),
    .tx_data_out(tx_data_out), .tx_last_out(tx_last_out),
    .tx_ready_in(tx_ready_in), .rx_valid_in(rx_valid_in),
    .rx_data_in(rx_data_in), .rx_last_in(rx_last_in),
    .rx_ready_out(rx_ready_out), .busy_out(busy_out), .done_out(done_out),
    .ok_out(ok_out), .status_out(status_out), .glob_sel_out(glob_sel_out),
    .glob_ctl_out(glob_ctl_out));
  pdbw_dev_model u_pdbw_dev_model (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .stall_in(stall), .go_in(go), .msg_in(msg_in),
    .tx_valid_in(tx_valid_out), .tx_data_in(tx_data_out),
    .tx_last_in(tx_last_out), .tx_ready_out(tx_ready_in),
    .rx_valid_out(rx_valid_in), .rx_data_out(rx_data_in),
    .rx_last_out(rx_last_in), .cap_out(cap), .ncap_out(ncap));

  initial begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end
  // image store answers one cycle after each read
  always @(posedge ref_clk_in) begin
    img_valid_in <= img_rd_out;
    img_data_in <= img_rd_out ? img[img_addr_out[7:0]] : ~img_data_in;
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // image fields are stored low byte first
  task automatic w8(input logic [31:0] a, input logic [7:0] v);
    img[a[7:0]] = v;
  endtask
  task automatic w32(input logic [31:0] a, input logic [31:0] v);
    for (int i = 0; i < 4; i++) w8(a + i, v[8*i +: 8]);
  endtask
  // upper byte of a word is don't care, so fill it with junk
  task automatic w16(input logic [31:0] a, input logic [7:0] v);
    w8(a, v);
    w8(a + 1, 8'hee);
  endtask
  task automatic blk(input logic [31:0] a, input logic [31:0] k,
                     input logic [31:0] skip);
    w32(a, k);
    w32(a + 4, skip);
  endtask
  task automatic msgw(input logic [31:0] a, input logic [31:0] m);
    for (int i = 0; i < 4; i++) w16(a + 2 * i, m[31 - 8 * i -: 8]);
  endtask
  task automatic st(input logic [31:0] a, input logic [15:0] s);
    blk(a, 32'h7, 32'h0);
    w32(a + 8, E);
    w8(a + 12, s[7:0]);
    w8(a + 13, s[15:8]);
  endtask
  task automatic cmpblk(input logic [31:0] a, input logic [31:0] k,
                        input logic [31:0] t, input logic [31:0] f);
    blk(a, k, 32'h0);
    w32(a + 8, t);
    w32(a + 12, f);
    msgw(a + 16, M);
  endtask
  task automatic run(input logic [31:0] p, input logic [15:0] s);
    int i;
    @(posedge ref_clk_in);
    first_ptr_in <= p;
    start_in <= 1'b1;
    @(posedge ref_clk_in);
    start_in <= 1'b0;
    i = 0;
    do begin
      @(posedge ref_clk_in);
      #1;
      i++;
    end while (done_out !== 1'b1 && i < 3000);
    chk("done", 32'h1, {31'h0, done_out});
    chk("status", {16'h0, s}, {16'h0, status_out});
    chk("ok", {31'h0, s == 16'h0}, {31'h0, ok_out});
    chk("busy", 32'h0, {31'h0, busy_out});
  endtask
  task automatic wait_rd(input logic [31:0] a);
    int i;
    i = 0;
    do begin
      @(posedge ref_clk_in);
      #1;
      i++;
    end while (!(img_rd_out === 1'b1 && img_addr_out === a) && i < 2000);
    chk("rd_addr", a, img_addr_out);
  endtask
  task automatic send(input logic [31:0] m);
    @(posedge ref_clk_in);
    msg_in <= m;
    go <= 1'b1;
    @(posedge ref_clk_in);
    go <= 1'b0;
    repeat (6) @(posedge ref_clk_in);
  endtask

  task automatic t_reset();
    @(posedge ref_clk_in);
    #1;
    chk("status_rst", 32'hfff, {16'h0, status_out});
    chk("sel_rst", 32'h0, {24'h0, glob_sel_out});
    chk("ctl_rst", 32'h0, {24'h0, glob_ctl_out});
    chk("rx_ready", 32'h1, {31'h0, rx_ready_out});
    chk("done_rst", 32'h0, {31'h0, done_out});
  endtask
  task automatic t_jump();
    blk(32'h40, 32'h1, 32'h0);
    w32(32'h48, 32'h60);
    blk(32'h60, 32'h20, 32'hc0);
    run(32'h40, 16'h0);
    run(32'hf0, 16'h0fff);
  endtask
  task automatic t_write();
    logic [7:0] n0;
    blk(32'h40, 32'h2, 32'h0);
    w32(32'h48, 32'hc0);
    msgw(32'h4c, 32'h11220133);
    n0 = ncap;
    run(32'h0, 16'h0);
    chk("tx_msg", 32'h11220133, cap);
    chk("tx_count", {24'h0, n0 + 8'h1}, {24'h0, ncap});
    chk("glob_sel", 32'h5a, {24'h0, glob_sel_out});
    chk("glob_ctl", 32'h3c, {24'h0, glob_ctl_out});
    stall <= 1'b1;
    run(32'h0, 16'h2);
    stall <= 1'b0;
    repeat (20) @(posedge ref_clk_in);
    // selector and control-high were held in the buffer across the stall
    chk("tx_held", 32'h01331122, cap);
    chk("tx_nolast", {24'h0, n0 + 8'h1}, {24'h0, ncap});
  endtask
  task automatic t_wait_next();
    cmpblk(32'h40, 32'h3, 32'hc0, 32'hd0);
    for (int k = 0; k < 3; k++) begin
      fork
        run(32'h0, k[15:0]);
        begin
          wait_rd(32'h47);
          if (k < 2) send(M + k);
        end
      join
    end
  endtask
  task automatic t_wait_spec();
    blk(32'h40, 32'h4, 32'h0);
    w32(32'h48, 32'hc0);
    msgw(32'h4c, M);
    for (int k = 0; k < 2; k++) begin
      fork
        run(32'h0, {k[14:0], 1'b0});
        begin
          wait_rd(32'h47);
          send(M ^ 32'h1);
          if (k == 0) begin
            // second message once the first one's last byte is being read at 32'h52, before it is judged
            wait_rd(32'h52);
            send(M);
          end
        end
      join
    end
  endtask
  task automatic t_last();
    cmpblk(32'h40, 32'h3, 32'h80, 32'h80);
    cmpblk(32'h80, 32'h5, 32'hc0, 32'hd0);
    for (int k = 0; k < 2; k++) begin
      fork
        run(32'h0, k[15:0]);
        begin
          wait_rd(32'h47);
          send(32'h3f000000);
          send(k == 0 ? M : M ^ 32'h100);
        end
      join
    end
  endtask

  initial begin
    err_count = 0;
    n_checks = 0;
    rst_in = 1'b1;
    start_in = 1'b0;
    first_ptr_in = 32'h0;
    img_len_in = E;
    img_valid_in = 1'b0;
    img_data_in = 8'h0;
    stall = 1'b0;
    go = 1'b0;
    msg_in = 32'h0;
    for (int i = 0; i < 256; i++) img[i] = 8'h5c;
    blk(32'h0, 32'h6, 32'h0);
    w32(32'h8, 32'h40);
    w32(32'hc, 32'he0);
    w32(32'h10, 32'd10);
    w16(32'h14, 8'h5a);
    w16(32'h16, 8'h3c);
    st(32'hc0, 16'h0);
    st(32'hd0, 16'h1);
    st(32'he0, 16'h2);
    blk(32'hf0, 32'h1, 32'h0);
    w32(32'hf8, E);
    repeat (16) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_jump();
    t_write();
    t_wait_next();
    t_wait_spec();
    t_last();
    print_verdict();
  end
  initial begin
    repeat (40000) @(posedge ref_clk_in);
    err_count++;
    print_verdict();
  end
endmodule
